//--- src/dcc_pkg.sv
// Purpose: Shared constants and types for the clock-change / DLL relock sequencer
// Assumes: Controller clock ref_clk at 20 MHz; DRAM command clock generated elsewhere
// Notes: Timing values in ns and derived cycle counts, command and register offsets
package dcc_pkg;

  localparam int unsigned REF_CLK_PS = 50000;

  // Timing values in ns (the _NCK ones in clocks), as defaults; cycle counts are rounded up
  localparam int unsigned T_CKSRE_NS = 10;
  localparam int unsigned T_CKSRX_NS = 10;
  localparam int unsigned T_XS_NS = 170;
  localparam int unsigned T_XP_NS = 24;
  localparam int unsigned T_MOD_NS = 15;
  localparam int unsigned T_MRD_NCK = 4;
  localparam int unsigned T_DLLK_NCK = 512;
  localparam int unsigned T_CLKSTAB_NS = 1000;

  function automatic int unsigned ns2cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + REF_CLK_PS - 1) / REF_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned C_CKSRE = ns2cyc(T_CKSRE_NS);
  localparam int unsigned C_CKSRX = ns2cyc(T_CKSRX_NS);
  localparam int unsigned C_XS = ns2cyc(T_XS_NS);
  localparam int unsigned C_XP = ns2cyc(T_XP_NS);
  localparam int unsigned C_MOD = ns2cyc(T_MOD_NS);
  localparam int unsigned C_CLKSTAB = ns2cyc(T_CLKSTAB_NS);

  localparam int unsigned CNT_W = 16;

  // Software register offsets (word index on the plain port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MR0 = 4'h2;
  localparam logic [3:0] REG_MR1 = 4'h3;
  localparam logic [3:0] REG_MR2 = 4'h4;
  localparam logic [3:0] REG_MR3 = 4'h5;

  // CTRL fields
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_PD_BIT = 1;
  localparam int unsigned CTRL_RTT_BIT = 2;
  // STATUS fields
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_CLKREQ_BIT = 2;
  localparam int unsigned ST_REFUSED_BIT = 3;

  // Mode register bits
  localparam int unsigned MR1_DLL_DIS_BIT = 0;
  localparam int unsigned MR0_DLL_RST_BIT = 8;

  localparam logic [15:0] MR0_RST = 16'h0000;
  localparam logic [15:0] MR1_RST = 16'h0001;
  localparam logic [15:0] MR2_RST = 16'h0000;
  localparam logic [15:0] MR3_RST = 16'h0000;

  // DRAM commands {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_SRE = 4'h1;

  typedef enum logic [12:0] {
    DCC_IDLE = 13'h0001,
    DCC_ENTER = 13'h0002,
    DCC_WAIT_SRE = 13'h0004,
    DCC_CLK_CHG = 13'h0008,
    DCC_CLK_STAB = 13'h0010,
    DCC_EXIT = 13'h0020,
    DCC_WAIT_XIT = 13'h0040,
    DCC_MRS1 = 13'h0080,
    DCC_MRS0 = 13'h0100,
    DCC_MRS2 = 13'h0200,
    DCC_MRS3 = 13'h0400,
    DCC_LOCK = 13'h0800,
    DCC_DONE = 13'h1000
  } dcc_state_t;

  typedef struct packed {
    logic cke;
    logic odt;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [15:0] addr;
  } dcc_dram_t;

endpackage

//--- src/dcc_seq.sv
// Purpose: Controller-side sequencer for DRAM clock frequency change and DLL relock
// Assumes: Software programs target mode register values; clock source is external
// Notes: Frequency switch is requested via clk_chg_req and confirmed by clk_chg_ack
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

// Operation
// RULE1 - From idle, enter self refresh, change clock, hold stable tCKSRX, exit
// RULE2 - After exit: MR1 A0 cleared, then MR0 A8 set, then other mode registers
// RULE3 - At least four clocks between two consecutive mode register writes
// RULE4 - Nanosecond parameters become cycle counts, rounded up
// RULE5 - Keep clock period constant outside allowed change windows
// RULE6 - Change clock only in self refresh or precharge power-down
// RULE7 - In self refresh, change clock after tCKSRE, stable before tCKSRX
// RULE8 - Self refresh entry and exit timings still apply when only changing clock
// RULE9 - New clock stays within the speed grade operating range
// RULE10 - With termination enabled, hold termination input low through power-down
// RULE11 - With termination disabled, memory keeps termination off anyway
// RULE12 - In power-down, wait tCKSRE after clock enable low before clock change
// RULE13 - Hold termination input and clock enable low while clock changes
// RULE14 - Provide stable new clock tCKSRX before leaving power-down
// RULE15 - After power-down exit and tXP, issue DLL reset by mode register write
// RULE16 - Rewrite write recovery and latencies as needed, clock enable kept high
// RULE17 - During DLL relock, termination input low and clock enable high
// RULE18 - After lock time the memory runs normally at the new clock
// RULE19 - Power-down change covers both exit kinds; termination off, outputs idle first
// RULE20 - MR1 A0 high disables the DLL until written back to zero
// RULE21 - Wait tDLLK after DLL reset before commands needing a locked DLL
// RULE22 - Each step its own state with a counter loaded from a rounded count
module dcc_seq
  import dcc_pkg::*;
#(
  parameter int unsigned DLLK_CYC = T_DLLK_NCK,
  parameter int unsigned CLKSTAB_CYC = C_CLKSTAB
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Software register port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // Clock source handshake
  output logic clk_chg_req,
  input wire logic clk_chg_ack,
  // Memory pins
  output dcc_dram_t dram,
  // Status
  output logic busy
);

  typedef struct packed {
    dcc_state_t st;
    logic [CNT_W-1:0] cnt;
    logic pd_mode;
    logic rtt_on;
    logic done;
    logic refused;
    logic [15:0] mr0;
    logic [15:0] mr1;
    logic [15:0] mr2;
    logic [15:0] mr3;
    logic [31:0] rdata;
    logic clk_req;
    dcc_dram_t dram;
    logic busy;
    logic ack_s1;
    logic ack_s2;
  } dcc_regs_t;

  dcc_regs_t r_q;
  dcc_regs_t r_d;

  localparam logic [CNT_W-1:0] CNT_CKSRE = CNT_W'(C_CKSRE);
  localparam logic [CNT_W-1:0] CNT_CKSRX = CNT_W'(C_CKSRX);
  localparam logic [CNT_W-1:0] CNT_XS = CNT_W'(C_XS);
  localparam logic [CNT_W-1:0] CNT_XP = CNT_W'(C_XP);
  localparam logic [CNT_W-1:0] CNT_MOD = CNT_W'(C_MOD);
  localparam logic [CNT_W-1:0] CNT_MRD = CNT_W'(T_MRD_NCK);
  localparam logic [CNT_W-1:0] CNT_DLLK = CNT_W'(DLLK_CYC);
  localparam logic [CNT_W-1:0] CNT_STAB = CNT_W'(CLKSTAB_CYC);

  logic cnt_zero;
  assign cnt_zero = (r_q.cnt == '0);

  always_comb begin
    r_d = r_q;
    r_d.ack_s1 = clk_chg_ack;
    r_d.ack_s2 = r_q.ack_s1;
    r_d.dram.cmd = CMD_NOP;
    r_d.dram.addr = '0;
    r_d.dram.ba = 3'h0;
    if (!cnt_zero) begin
      r_d.cnt = r_q.cnt - CNT_W'(1);
    end

    // Software writes; mode register values are frozen while busy is high
    if (sw_wr) begin
      case (sw_addr)
        REG_CTRL: begin
          if (sw_wdata[CTRL_GO_BIT]) begin
            if (r_q.st == DCC_IDLE || r_q.st == DCC_DONE) begin
              r_d.pd_mode = sw_wdata[CTRL_PD_BIT];
              r_d.rtt_on = sw_wdata[CTRL_RTT_BIT];
              r_d.done = 1'b0;
              r_d.st = DCC_ENTER;
            end else begin
              r_d.refused = 1'b1;
            end
          end
        end
        REG_STATUS: begin
          if (sw_wdata[ST_DONE_BIT]) r_d.done = 1'b0;
          if (sw_wdata[ST_REFUSED_BIT]) r_d.refused = 1'b0;
        end
        REG_MR0: if (!r_q.busy) r_d.mr0 = sw_wdata[15:0];
        REG_MR1: if (!r_q.busy) r_d.mr1 = sw_wdata[15:0];
        REG_MR2: if (!r_q.busy) r_d.mr2 = sw_wdata[15:0];
        REG_MR3: if (!r_q.busy) r_d.mr3 = sw_wdata[15:0];
        default: ;
      endcase
    end

    r_d.rdata = 32'h0000_0000;
    if (sw_rd) begin
      case (sw_addr)
        REG_CTRL: r_d.rdata = {29'h0, r_q.rtt_on, r_q.pd_mode, 1'b0};
        REG_STATUS: r_d.rdata = {28'h0, r_q.refused, r_q.clk_req, r_q.done, r_q.busy};
        REG_MR0: r_d.rdata = {16'h0, r_q.mr0};
        REG_MR1: r_d.rdata = {16'h0, r_q.mr1};
        REG_MR2: r_d.rdata = {16'h0, r_q.mr2};
        REG_MR3: r_d.rdata = {16'h0, r_q.mr3};
        default: r_d.rdata = 32'h0000_0000;
      endcase
    end

    case (r_q.st)
      DCC_IDLE: begin
        r_d.busy = 1'b0;
      end
      DCC_ENTER: begin
        // Banks assumed idle and termination already off on entry
        r_d.busy = 1'b1;
        r_d.dram.cke = 1'b0; // RULE1 RULE12
        r_d.dram.odt = 1'b0; // RULE10 RULE19
        if (!r_q.pd_mode) begin
          r_d.dram.cmd = CMD_SRE; // RULE1
        end
        r_d.cnt = CNT_CKSRE; // RULE22
        r_d.st = DCC_WAIT_SRE;
      end
      DCC_WAIT_SRE: begin
        if (cnt_zero) begin
          // Only retune window; new rate range is up to the clock source
          r_d.clk_req = 1'b1; // RULE5 RULE6 RULE7 RULE9 RULE12
          r_d.st = DCC_CLK_CHG;
        end
      end
      DCC_CLK_CHG: begin
        // CKE and ODT remain low while the source retunes
        r_d.dram.cke = 1'b0; // RULE13
        r_d.dram.odt = 1'b0; // RULE13
        if (r_q.ack_s2) begin
          r_d.clk_req = 1'b0;
          r_d.cnt = CNT_STAB;
          r_d.st = DCC_CLK_STAB;
        end
      end
      DCC_CLK_STAB: begin
        // Ack only says the source is retuned; settle then count tCKSRX
        if (r_q.ack_s2) begin
          r_d.cnt = CNT_STAB;
        end else if (cnt_zero) begin
          r_d.cnt = CNT_CKSRX; // RULE7 RULE14
          r_d.st = DCC_EXIT;
        end
      end
      DCC_EXIT: begin
        if (cnt_zero) begin
          r_d.dram.cke = 1'b1; // RULE1 RULE8 RULE14
          r_d.cnt = r_q.pd_mode ? CNT_XP : CNT_XS; // RULE8 RULE15 RULE4
          r_d.st = DCC_WAIT_XIT;
        end
      end
      DCC_WAIT_XIT: begin
        if (cnt_zero) r_d.st = DCC_MRS1;
      end
      DCC_MRS1: begin
        if (cnt_zero) begin
          if (r_q.pd_mode) begin
            r_d.st = DCC_MRS0;
          end else begin
            r_d.dram.cmd = CMD_MRS;
            r_d.dram.ba = 3'h1;
            r_d.dram.addr = r_q.mr1;
            r_d.dram.addr[MR1_DLL_DIS_BIT] = 1'b0; // RULE2 RULE20
            r_d.cnt = CNT_MRD; // RULE3
            r_d.st = DCC_MRS0;
          end
        end
      end
      DCC_MRS0: begin
        if (cnt_zero) begin
          r_d.dram.cmd = CMD_MRS;
          r_d.dram.ba = 3'h0;
          r_d.dram.addr = r_q.mr0;
          r_d.dram.addr[MR0_DLL_RST_BIT] = 1'b1; // RULE2 RULE15
          r_d.cnt = CNT_MRD; // RULE3
          r_d.st = DCC_MRS2;
        end
      end
      DCC_MRS2: begin
        if (cnt_zero) begin
          r_d.dram.cmd = CMD_MRS;
          r_d.dram.ba = 3'h2;
          r_d.dram.addr = r_q.mr2; // RULE16
          r_d.cnt = CNT_MRD; // RULE3
          r_d.st = DCC_MRS3;
        end
      end
      DCC_MRS3: begin
        if (cnt_zero) begin
          r_d.dram.cmd = CMD_MRS;
          r_d.dram.ba = 3'h3;
          r_d.dram.addr = r_q.mr3; // RULE16
          // Lock wait from the DLL reset exceeds tMOD from this write
          r_d.cnt = (CNT_DLLK > CNT_MOD) ? CNT_DLLK - CNT_W'(2 * T_MRD_NCK) : CNT_MOD;
          r_d.st = DCC_LOCK;
        end
      end
      DCC_LOCK: begin
        // CKE high and ODT low held through relock
        r_d.dram.cke = 1'b1; // RULE17
        r_d.dram.odt = 1'b0; // RULE17
        if (cnt_zero) begin
          r_d.st = DCC_DONE; // RULE21 RULE18
        end
      end
      DCC_DONE: begin
        r_d.done = 1'b1;
        r_d.busy = 1'b0;
        r_d.mr1[MR1_DLL_DIS_BIT] = 1'b0; // RULE20
        // One-shot set, so software can clear done afterwards
        r_d.st = DCC_IDLE;
      end
      default: begin
        r_d.st = DCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_q.st <= DCC_IDLE;
      r_q.cnt <= '0;
      r_q.pd_mode <= 1'b0;
      r_q.rtt_on <= 1'b0;
      r_q.done <= 1'b0;
      r_q.refused <= 1'b0;
      r_q.mr0 <= MR0_RST;
      r_q.mr1 <= MR1_RST;
      r_q.mr2 <= MR2_RST;
      r_q.mr3 <= MR3_RST;
      r_q.rdata <= 32'h0000_0000;
      r_q.clk_req <= 1'b0;
      r_q.dram.cke <= 1'b1;
      r_q.dram.odt <= 1'b0;
      r_q.dram.cmd <= CMD_NOP;
      r_q.dram.ba <= 3'h0;
      r_q.dram.addr <= 16'h0000;
      r_q.busy <= 1'b0;
      r_q.ack_s1 <= 1'b0;
      r_q.ack_s2 <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign sw_rdata = r_q.rdata;
  assign clk_chg_req = r_q.clk_req;
  assign dram = r_q.dram;
  assign busy = r_q.busy;

endmodule

//--- verif/dcc_dram_model.sv
// Purpose: Behavioural memory seen from its pins
// Assumes: Clock retune shown by clk_chg high
// Notes: Counts rule breaks, records mode writes
`timescale 1ns/1ps
module dcc_dram_model
  import dcc_pkg::*;
#(
  parameter int unsigned DLLK_CYC = 16,
  parameter int unsigned RTT_NOM_BIT = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins
  input wire dcc_dram_t dram,
  input wire logic clk_chg,
  // Observed state
  output logic [63:0] mr_q,
  output logic [11:0] ord_q,
  output logic sr_q,
  output logic locked_q,
  output logic [7:0] bad_q
);
  logic cke_q;
  logic [15:0] lock_cnt_q;
  logic rtt_on;
  assign rtt_on = dram.odt && dram.cke && mr_q[16 + RTT_NOM_BIT];
  // Lock time counted in input clocks
  assign locked_q = !mr_q[16 + MR1_DLL_DIS_BIT] && 32'(lock_cnt_q) >= DLLK_CYC;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mr_q <= 64'h0000_0000_0001_0000;
      {ord_q, sr_q, bad_q, cke_q, lock_cnt_q} <= '0;
    end else begin
      cke_q <= dram.cke;
      if (cke_q && !dram.cke) begin
        ord_q <= 12'h000;
        sr_q <= (dram.cmd == CMD_SRE);
      end
      if (dram.cmd == CMD_MRS && dram.cke) begin
        mr_q[16 * dram.ba[1:0] +: 16] <= dram.addr;
        ord_q <= {ord_q[8:0], dram.ba};
      end
      if (dram.cmd == CMD_MRS && dram.ba == 3'h0 && dram.addr[MR0_DLL_RST_BIT]) begin
        lock_cnt_q <= 16'h0000;
      end else if (lock_cnt_q != 16'hFFFF) begin
        lock_cnt_q <= lock_cnt_q + 16'h0001;
      end
      // Retune only with enable and termination low
      if (clk_chg && (dram.cke || dram.odt || rtt_on)) begin
        bad_q <= bad_q + 8'h01;
      end
    end
  end
endmodule

//--- verif/dcc_seq_asserts.sv
// Purpose: Port checker for dcc_seq
// Assumes: One ref_clk domain, rst async active high
// Notes: Bound to every dcc_seq instance
`timescale 1ns/1ps
module dcc_seq_asserts
  import dcc_pkg::*;
#(
  parameter int unsigned DLLK_CYC = T_DLLK_NCK,
  parameter int unsigned CLKSTAB_CYC = C_CLKSTAB
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Observed ports
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire logic clk_chg_req,
  input wire dcc_dram_t dram,
  input wire logic busy
);
  logic [15:0] lock_cnt_q;
  // Cycles since the last DLL reset write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_cnt_q <= 16'h0000;
    end else if (dram.cmd == CMD_MRS && dram.ba == 3'h0) begin
      lock_cnt_q <= 16'h0001;
    end else if (lock_cnt_q != 16'hFFFF) begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_mrs_gap_four: assert property (dram.cmd == CMD_MRS |=> (dram.cmd != CMD_MRS)[*3])
    else $error("mode writes too close");
  a_dll_on_first: assert property (dram.cmd == CMD_MRS && dram.ba == 3'h1 |->
    !dram.addr[MR1_DLL_DIS_BIT] ##5 (dram.cmd == CMD_MRS && dram.ba == 3'h0))
    else $error("enable write not followed by reset write");
  a_mr0_dll_reset: assert property (dram.cmd == CMD_MRS && dram.ba == 3'h0 |-> dram.addr[MR0_DLL_RST_BIT])
    else $error("reset write lacks reset bit");
  a_mrs_cke_high: assert property (dram.cmd == CMD_MRS |-> dram.cke && !dram.odt)
    else $error("mode write with enable low");
  a_req_pins_low: assert property (clk_chg_req |-> !dram.cke && !dram.odt)
    else $error("retune allowed with pins not low");
  a_cksre_wait: assert property ($rose(clk_chg_req) |-> !$past(dram.cke) && !$past(dram.cke, 2))
    else $error("retune allowed too early");
  a_cksrx_hold: assert property ($fell(clk_chg_req) |-> (!dram.cke)[*3])
    else $error("exit too soon after retune");
  a_busy_odt_low: assert property (busy |-> !dram.odt)
    else $error("termination input high while busy");
  a_lock_wait: assert property ($fell(busy) |-> 32'(lock_cnt_q) >= DLLK_CYC)
    else $error("done before lock time");
  a_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind dcc_seq dcc_seq_asserts #(.DLLK_CYC(DLLK_CYC), .CLKSTAB_CYC(CLKSTAB_CYC)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
  .clk_chg_req(clk_chg_req), .dram(dram), .busy(busy));

//--- verif/dram_clock_change_dll_relock_tb_top.sv
// Purpose: Register-level test of dcc_seq
// Assumes: Short lock and stability counts
// Notes: Bench plays software and clock source
`timescale 1ns/1ps
module dram_clock_change_dll_relock_tb_top;
  import dcc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic clk_chg_ack = 1'b0;
  logic [31:0] sw_rdata;
  logic clk_chg_req, busy, sr, locked;
  dcc_dram_t dram;
  logic [63:0] mr;
  logic [11:0] ord;
  logic [7:0] bad;
  int fails = 0;
  int checks_done = 0;
  always #25 ref_clk = ~ref_clk;
  dcc_seq #(.DLLK_CYC(16), .CLKSTAB_CYC(2)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .clk_chg_req(clk_chg_req), .clk_chg_ack(clk_chg_ack),
    .dram(dram), .busy(busy));
  dcc_dram_model #(.DLLK_CYC(16)) mem_u (.ref_clk(ref_clk), .rst(rst), .dram(dram),
    .clk_chg(clk_chg_ack), .mr_q(mr), .ord_q(ord), .sr_q(sr), .locked_q(locked), .bad_q(bad));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    @(negedge ref_clk);
    cmp(sw_rdata, exp);
  endtask
  // Bounded wait on busy (k=1) or the retune request (k=0)
  task automatic wait_sig(input int k, input logic lvl);
    int n;
    n = 0;
    while ((k ? busy : clk_chg_req) !== lvl && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 300) fails++;
  endtask
  task automatic run_seq(input logic [31:0] ctrl, input logic [11:0] exp_ord, input logic exp_sr);
    wr(REG_CTRL, ctrl);
    wr(REG_CTRL, ctrl);
    wr(REG_MR2, 32'h0000FFFF);
    wait_sig(0, 1'b1);
    rd(REG_STATUS, 32'h0000000D);
    @(posedge ref_clk);
    clk_chg_ack <= 1'b1;
    wait_sig(0, 1'b0);
    repeat (2) @(posedge ref_clk);
    clk_chg_ack <= 1'b0;
    wait_sig(1, 1'b0);
    cmp({20'h0, ord}, {20'h0, exp_ord});
    cmp({31'h0, sr}, {31'h0, exp_sr});
    cmp(mr[31:0], 32'h0044_0520);
    cmp(mr[63:32], 32'h0000_0018);
    cmp({31'h0, locked}, 32'h1);
    cmp({24'h0, bad}, 32'h0);
    rd(REG_STATUS, 32'h0000000A);
    wr(REG_STATUS, 32'h0000000A);
    rd(REG_STATUS, 32'h0);
    rd(REG_MR2, 32'h0000_0018);
  endtask
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_STATUS, 32'h0);
    rd(REG_CTRL, 32'h0);
    rd(4'hF, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(4'(REG_MR0 + i), (i == 1) ? 32'h1 : 32'h0);
    end
    wr(REG_MR0, 32'h0420);
    wr(REG_MR1, 32'h0045);
    wr(REG_MR2, 32'h0018);
    wr(REG_MR3, 32'h0);
    rd(REG_MR1, 32'h0045);
    run_seq(32'h1, 12'h213, 1'b1);
    run_seq(32'h7, 12'h013, 1'b0);
    rd(REG_CTRL, 32'h0000_0006);
    rd(REG_MR0, 32'h0000_0420);
    rd(REG_MR1, 32'h0000_0044);
    wrap_up();
  end
endmodule
